// ==== design/cbx_class_if.sv ====
`timescale 1ns/100ps
interface cbx_class_if;
   logic [10:0] id;
   logic [3:0] dlc;
   logic [6:0] node;
   cbx_pkg::cbx_kind_t kind;
   modport main (output id, output dlc, output node, input kind);
   modport cls (input id, input dlc, input node, output kind);
endinterface

// ==== design/cbx_fifo.sv ====
`timescale 1ns/100ps
module cbx_fifo #(
   parameter int WIDTH = 79,
   parameter int DEPTH = 16
) (
   // Clock and control
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic ce,
   // Filling side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // Draining side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
      $error("cbx_fifo: DEPTH must be a power of two >= 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_q, rd_q;
   logic [AW:0] cnt_q, cnt_d;
   logic push, pop;

   // Pointers wrap naturally since depth is a power of two
   assign push = ce & in_valid & in_ready;
   assign pop = ce & out_valid & out_ready;
   assign out_valid = (cnt_q != '0);
   assign out_data = mem[rd_q];
   assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

   // Occupancy and a registered ready, so full is honest at the port
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cnt_q <= '0;
         in_ready <= 1'b1;
      end else if (ce) begin
         cnt_q <= cnt_d;
         in_ready <= (cnt_d != (AW+1)'(DEPTH));
      end
   end

   // Pointers
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) wr_q <= wr_q + 1'b1;
         if (pop) rd_q <= rd_q + 1'b1;
      end
   end

   // Storage, no reset needed
   always_ff @(posedge core_clk) begin
      if (push) mem[wr_q] <= in_data;
   end
endmodule

// ==== design/cbx_frame_class.sv ====
`timescale 1ns/100ps
module cbx_frame_class (
   // Frame header and active node address in, kind out
   cbx_class_if.cls c
);
   // Decode one received frame header
   always_comb begin
      c.kind = cbx_pkg::K_NONE;
      if (c.id == cbx_pkg::SYNC_ID && c.dlc == cbx_pkg::SYNC_DLC) begin
         c.kind = cbx_pkg::K_SYNC;
      end else if (c.id[10:4] == cbx_pkg::BLK_SEND_PFX && c.dlc == cbx_pkg::BLK_DLC
                   && cbx_pkg::blk_addr_ok(c.node) && c.id[3:0] == c.node[3:0]) begin
         c.kind = cbx_pkg::K_BLK;
      end else if (c.id == cbx_pkg::NMT_ID && c.dlc == cbx_pkg::NMT_DLC) begin
         c.kind = cbx_pkg::K_NMT;
      end else if (c.node != 7'h00 && c.id == cbx_pkg::cob(cbx_pkg::SDO_RX_BASE, c.node)) begin
         c.kind = cbx_pkg::K_SDO;
      end else if (c.node != 7'h00 && c.id == cbx_pkg::cob(cbx_pkg::GUARD_BASE, c.node)) begin
         c.kind = cbx_pkg::K_GUARD;
      end
   end
endmodule

// ==== design/cbx_node.sv ====
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
module cbx_node #(
   parameter int FIFO_DEPTH = cbx_pkg::RX_FIFO_DEPTH
) (
   // Clock, reset and clock enable
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic ce,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // Received frames
   input wire logic rx_valid,
   input wire logic [10:0] rx_id,
   input wire logic [3:0] rx_dlc,
   input wire logic [63:0] rx_data,
   output logic rx_ready,
   // Frames to transmit
   output logic tx_valid,
   output logic [10:0] tx_id,
   output logic [3:0] tx_dlc,
   output logic [63:0] tx_data,
   input wire logic tx_ready,
   // Application requests
   input wire logic emcy_req,
   input wire logic [63:0] emcy_data,
   input wire logic sdo_resp_req,
   input wire logic [63:0] sdo_resp_data,
   // Application status
   output logic sdo_req_valid,
   output logic [63:0] sdo_req_data,
   output logic [7:0] nmt_state,
   output logic [6:0] node_id,
   output logic [9:0] bit_rate_kbps,
   output logic sync_pulse
);
   localparam int FW = cbx_pkg::ID_W + cbx_pkg::DLC_W + cbx_pkg::DATA_W;

   logic [15:0] rate_q, act_rate_q;
   logic [6:0] addr_q, act_addr_q;
   logic reinit_q, apply;
   logic [63:0] blk_q, rxp_q, txp_q, emcy_q, sdo_q;
   logic blk_valid_q, sync_flag_q, toggle_q;
   logic boot_pend_q, emcy_pend_q, sdo_pend_q;
   cbx_pkg::cbx_nmt_t st_q, st_d;
   logic [FW-1:0] f_out;
   logic f_valid, take;
   logic [10:0] f_id;
   logic [3:0] f_dlc;
   logic [63:0] f_data;
   cbx_pkg::cbx_kind_t kind;
   logic is_sync, is_blk, is_nmt, is_sdo, is_guard;
   logic nmt_hit, nmt_rst, node_ok, can_send;
   logic ld_reply, ld_guard, ld_boot, ld_emcy, ld_sdo;
   logic [7:0] guard_byte;
   logic [15:0] rd_mux;

   // Received frames queue up; stalls while any transmit frame is waiting to leave
   cbx_fifo #(
      .WIDTH(FW),
      .DEPTH(FIFO_DEPTH)
   ) u_rx_fifo (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .ce(ce),
      .in_valid(rx_valid),
      .in_data({rx_id, rx_dlc, rx_data}),
      .in_ready(rx_ready),
      .out_valid(f_valid),
      .out_data(f_out),
      .out_ready(~tx_valid)
   );

   assign {f_id, f_dlc, f_data} = f_out;

   cbx_class_if u_cls_if ();

   assign u_cls_if.id = f_id;
   assign u_cls_if.dlc = f_dlc;
   assign u_cls_if.node = act_addr_q;
   assign kind = u_cls_if.kind;

   cbx_frame_class u_cls (
      .c(u_cls_if)
   );

   // One frame consumed per cycle, only when the transmitter is free
   assign take = ce & f_valid & ~tx_valid;
   assign is_sync = take && kind == cbx_pkg::K_SYNC;
   assign is_blk = take && kind == cbx_pkg::K_BLK;
   assign is_nmt = take && kind == cbx_pkg::K_NMT;
   assign is_sdo = take && kind == cbx_pkg::K_SDO;
   assign is_guard = take && kind == cbx_pkg::K_GUARD;

   // NMT addressed to all nodes or to this one
   assign nmt_hit = is_nmt && (f_data[15:8] == 8'h00 || f_data[15:8] == {1'b0, act_addr_q});
   assign nmt_rst = nmt_hit && (f_data[7:0] == cbx_pkg::NMT_RST_NODE
                                || f_data[7:0] == cbx_pkg::NMT_RST_COMM);
   assign apply = ce & (reinit_q | nmt_rst);

   // Setting registers, written by software only
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rate_q <= cbx_pkg::RATE_RST;
         addr_q <= cbx_pkg::ADDR_RST;
      end else if (ce && reg_wr) begin
         if (reg_addr == cbx_pkg::REG_RATE) rate_q <= {1'b0, reg_wdata[14:0]};
         if (reg_addr == cbx_pkg::REG_ADDR) addr_q <= reg_wdata[6:0];
      end
   end

   // Reinit command lives one cycle, then the settings are applied
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         reinit_q <= 1'b0;
      end else if (ce) begin
         reinit_q <= reg_wr && reg_addr == cbx_pkg::REG_CTRL
                     && reg_wdata[cbx_pkg::CTRL_REINIT];
      end
   end

   // Active settings change only on apply; reset stands for power-on
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         act_rate_q <= cbx_pkg::RATE_RST;
         act_addr_q <= cbx_pkg::ADDR_RST;
         node_id <= cbx_pkg::ADDR_RST;
         bit_rate_kbps <= cbx_pkg::KBPS_RST;
      end else if (apply) begin
         act_rate_q <= rate_q;
         act_addr_q <= addr_q;
         node_id <= addr_q;
         bit_rate_kbps <= cbx_pkg::rate_kbps(rate_q);
      end
   end

   // Block buffer; live parameters untouched until sync
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         blk_q <= 64'h0;
         blk_valid_q <= 1'b0;
      end else if (is_blk) begin
         blk_q <= f_data;
         blk_valid_q <= 1'b1;
      end else if (is_sync) begin
         blk_valid_q <= 1'b0;
      end
   end

   // Receive parameters commit on sync only if a block arrived
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rxp_q <= 64'h0;
      end else if (is_sync && blk_valid_q) begin
         rxp_q <= blk_q;
      end
   end

   // Transmit parameters, low word is the first one
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         txp_q <= 64'h0;
      end else if (ce && reg_wr && reg_addr[3:2] == cbx_pkg::REG_TXP_HI) begin
         txp_q[{reg_addr[1:0], 4'h0} +: 16] <= reg_wdata;
      end
   end

   // Sticky sync flag; a new sync beats a clear in the same cycle
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         sync_flag_q <= 1'b0;
         sync_pulse <= 1'b0;
      end else if (ce) begin
         sync_pulse <= is_sync;
         if (is_sync) begin
            sync_flag_q <= 1'b1;
         end else if (reg_wr && reg_addr == cbx_pkg::REG_STAT
                      && reg_wdata[cbx_pkg::ST_SYNC]) begin
            sync_flag_q <= 1'b0;
         end
      end
   end

   // NMT state: boot after init, pre-operational once boot-up is out
   always_comb begin
      st_d = st_q;
      if (apply) begin
         st_d = cbx_pkg::ST_BOOT;
      end else if (ld_boot) begin
         st_d = cbx_pkg::ST_PREOP;
      end else if (nmt_hit) begin
         case (f_data[7:0])
            cbx_pkg::NMT_START: st_d = cbx_pkg::ST_OPER;
            cbx_pkg::NMT_STOP: st_d = cbx_pkg::ST_STOPPED;
            cbx_pkg::NMT_PREOP: st_d = cbx_pkg::ST_PREOP;
            default: st_d = st_q;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st_q <= cbx_pkg::ST_BOOT;
         nmt_state <= cbx_pkg::nmt_code(cbx_pkg::ST_BOOT);
      end else if (ce) begin
         st_q <= st_d;
         nmt_state <= cbx_pkg::nmt_code(st_d);
      end
   end

   // Transmit choice: frame replies first, then boot-up, emergency, SDO
   assign node_ok = act_addr_q != 7'h00;
   assign can_send = ce && !tx_valid && node_ok;
   assign ld_reply = is_sync && cbx_pkg::blk_addr_ok(act_addr_q);
   assign ld_guard = is_guard;
   assign ld_boot = can_send && !take && boot_pend_q;
   assign ld_emcy = can_send && !take && !boot_pend_q && emcy_pend_q
                    && st_q != cbx_pkg::ST_STOPPED && st_q != cbx_pkg::ST_BOOT;
   assign ld_sdo = can_send && !take && !boot_pend_q && !emcy_pend_q && sdo_pend_q
                   && st_q != cbx_pkg::ST_STOPPED && st_q != cbx_pkg::ST_BOOT;
   assign guard_byte = {toggle_q, 7'(cbx_pkg::nmt_code(st_q))}; // Low seven bits of state code

   // Pending sends; a new request wins over the load that clears it
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         boot_pend_q <= 1'b1;
         emcy_pend_q <= 1'b0;
         sdo_pend_q <= 1'b0;
         emcy_q <= 64'h0;
         sdo_q <= 64'h0;
      end else if (ce) begin
         if (apply) boot_pend_q <= 1'b1;
         else if (ld_boot) boot_pend_q <= 1'b0;
         if (emcy_req) begin
            emcy_pend_q <= 1'b1;
            emcy_q <= emcy_data;
         end else if (ld_emcy) begin
            emcy_pend_q <= 1'b0;
         end
         if (sdo_resp_req) begin
            sdo_pend_q <= 1'b1;
            sdo_q <= sdo_resp_data;
         end else if (ld_sdo) begin
            sdo_pend_q <= 1'b0;
         end
      end
   end

   // Guarding toggle bit flips with every guarding answer
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         toggle_q <= 1'b0;
      end else if (apply) begin
         toggle_q <= 1'b0;
      end else if (ld_guard) begin
         toggle_q <= ~toggle_q;
      end
   end

   // Transmit holding register, stands until tx_ready
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         tx_valid <= 1'b0;
         tx_id <= 11'h000;
         tx_dlc <= 4'h0;
         tx_data <= 64'h0;
      end else if (ce) begin
         if (tx_valid && tx_ready) tx_valid <= 1'b0;
         if (ld_reply) begin
            tx_valid <= 1'b1;
            tx_id <= {cbx_pkg::BLK_REPLY_PFX, act_addr_q[3:0]};
            tx_dlc <= cbx_pkg::BLK_DLC;
            tx_data <= txp_q;
         end else if (ld_guard) begin
            tx_valid <= 1'b1;
            tx_id <= cbx_pkg::cob(cbx_pkg::GUARD_BASE, act_addr_q);
            tx_dlc <= cbx_pkg::GUARD_DLC;
            tx_data <= {56'h0, guard_byte};
         end else if (ld_boot) begin
            tx_valid <= 1'b1;
            tx_id <= cbx_pkg::cob(cbx_pkg::GUARD_BASE, act_addr_q);
            tx_dlc <= cbx_pkg::GUARD_DLC;
            tx_data <= 64'h0;
         end else if (ld_emcy) begin
            tx_valid <= 1'b1;
            tx_id <= cbx_pkg::cob(cbx_pkg::EMCY_BASE, act_addr_q);
            tx_dlc <= cbx_pkg::BLK_DLC;
            tx_data <= emcy_q;
         end else if (ld_sdo) begin
            tx_valid <= 1'b1;
            tx_id <= cbx_pkg::cob(cbx_pkg::SDO_TX_BASE, act_addr_q);
            tx_dlc <= cbx_pkg::BLK_DLC;
            tx_data <= sdo_q;
         end
      end
   end

   // SDO requests handed to the application as a one-cycle strobe
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         sdo_req_valid <= 1'b0;
         sdo_req_data <= 64'h0;
      end else if (ce) begin
         sdo_req_valid <= is_sdo;
         if (is_sdo) sdo_req_data <= f_data;
      end
   end

   // Read mux; unmapped indices read zero
   always_comb begin
      rd_mux = 16'h0000;
      if (reg_addr[3:2] == cbx_pkg::REG_RXP_HI) begin
         rd_mux = rxp_q[{reg_addr[1:0], 4'h0} +: 16];
      end else if (reg_addr[3:2] == cbx_pkg::REG_TXP_HI) begin
         rd_mux = txp_q[{reg_addr[1:0], 4'h0} +: 16];
      end else begin
         case (reg_addr)
            cbx_pkg::REG_RATE: rd_mux = rate_q;
            cbx_pkg::REG_ADDR: rd_mux = {9'h000, addr_q};
            cbx_pkg::REG_CTRL: rd_mux = {15'h0000, reinit_q};
            cbx_pkg::REG_STAT: rd_mux = {1'b0, act_addr_q, 6'h00, blk_valid_q, sync_flag_q};
            default: rd_mux = 16'h0000;
         endcase
      end
   end

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         reg_rdata <= 16'h0000;
      end else if (ce) begin
         reg_rdata <= reg_rd ? rd_mux : 16'h0000;
      end
   end

   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_blk_buffered: assert property (is_blk |=> blk_valid_q && blk_q == $past(f_data))
      else $error("block not buffered");
   a_blk_not_live: assert property (is_blk |=> rxp_q == $past(rxp_q))
      else $error("block applied before sync");
   a_addr_filter: assert property (take && f_id[10:4] == cbx_pkg::BLK_SEND_PFX
      && f_id[3:0] != act_addr_q[3:0] |-> kind != cbx_pkg::K_BLK)
      else $error("foreign block accepted");
   a_sync_commit: assert property (is_sync && blk_valid_q |=> rxp_q == $past(blk_q))
      else $error("sync did not commit block");
   a_reply_frame: assert property (ld_reply |=> tx_valid && tx_dlc == cbx_pkg::BLK_DLC
      && tx_id == {7'h42, $past(act_addr_q[3:0])} && tx_data == $past(txp_q))
      else $error("bad block reply");
   a_sync_flag: assert property (is_sync |=> sync_flag_q ##1 (sync_flag_q || !ce
      || $past(reg_wr)))
      else $error("sync flag not set");
   a_keep_rxp: assert property (is_sync && !blk_valid_q |=> rxp_q == $past(rxp_q))
      else $error("receive parameters changed");
   a_rate_defer: assert property (ce && !reinit_q && !nmt_rst |=> $stable(act_rate_q)
      && $stable(act_addr_q))
      else $error("setting applied early");
   a_reinit_apply: assert property (ce && reinit_q |=> act_rate_q == $past(rate_q)
      && bit_rate_kbps == cbx_pkg::rate_kbps($past(rate_q)))
      else $error("reinit not applied");
   a_tx_cob: assert property ($rose(tx_valid) && tx_id[10:7] != 4'h8 |->
      tx_id[6:0] == act_addr_q && act_addr_q != 7'h00)
      else $error("node id missing from identifier");
   a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("transmit frame dropped");

   c_sync_blk: cover property (is_blk ##[1:20] is_sync);
   c_sync_empty: cover property (is_sync && !blk_valid_q);
   c_fifo_full: cover property (!rx_ready);
   c_reinit: cover property (reinit_q ##[1:10] ld_boot);
endmodule

// ==== design/cbx_pkg.sv ====
package cbx_pkg;
   // Frame field widths
   localparam int ID_W = 11;
   localparam int DLC_W = 4;
   localparam int DATA_W = 64;
   localparam int RX_FIFO_DEPTH = 16;
   // Block exchange identifiers
   localparam logic [10:0] SYNC_ID = 11'h400;
   localparam logic [6:0] BLK_SEND_PFX = 7'h41;
   localparam logic [6:0] BLK_REPLY_PFX = 7'h42;
   localparam logic [3:0] BLK_DLC = 4'h8;
   localparam logic [3:0] SYNC_DLC = 4'h0;
   // Predefined identifiers; node address added to the bases, not to NMT_ID
   localparam logic [10:0] NMT_ID = 11'h000;
   localparam logic [3:0] NMT_DLC = 4'h2;
   localparam logic [10:0] EMCY_BASE = 11'h080;
   localparam logic [10:0] SDO_TX_BASE = 11'h580;
   localparam logic [10:0] SDO_RX_BASE = 11'h600;
   localparam logic [10:0] GUARD_BASE = 11'h700;
   localparam logic [3:0] GUARD_DLC = 4'h1;
   // Network management commands
   localparam logic [7:0] NMT_START = 8'h01;
   localparam logic [7:0] NMT_STOP = 8'h02;
   localparam logic [7:0] NMT_PREOP = 8'h80;
   localparam logic [7:0] NMT_RST_NODE = 8'h81;
   localparam logic [7:0] NMT_RST_COMM = 8'h82;
   // Register indices
   localparam logic [3:0] REG_RATE = 4'h0;
   localparam logic [3:0] REG_ADDR = 4'h1;
   localparam logic [3:0] REG_CTRL = 4'h2;
   localparam logic [3:0] REG_STAT = 4'h3;
   localparam logic [1:0] REG_RXP_HI = 2'h1;
   localparam logic [1:0] REG_TXP_HI = 2'h2;
   // Field positions and reset values
   localparam int CTRL_REINIT = 0;
   localparam int ST_SYNC = 0;
   localparam int ST_BLK = 1;
   localparam logic [15:0] RATE_RST = 16'h0001;
   localparam logic [6:0] ADDR_RST = 7'h01;

   typedef enum logic [2:0] {K_NONE, K_BLK, K_SYNC, K_NMT, K_SDO, K_GUARD} cbx_kind_t;
   typedef enum logic [1:0] {ST_BOOT, ST_PREOP, ST_OPER, ST_STOPPED} cbx_nmt_t;

   // Bit rate code to kbit/s, zero for an unsupported code
   function automatic logic [9:0] rate_kbps(input logic [15:0] code);
      case (code)
         16'h0000: rate_kbps = 10'h07d;
         16'h0001: rate_kbps = 10'h3e8;
         16'h0002: rate_kbps = 10'h1f4;
         16'h0003: rate_kbps = 10'h0fa;
         16'h0004: rate_kbps = 10'h07d;
         16'h0005: rate_kbps = 10'h032;
         16'h0006: rate_kbps = 10'h014;
         16'h0007: rate_kbps = 10'h00a;
         default: rate_kbps = 10'h000;
      endcase
   endfunction

   localparam logic [9:0] KBPS_RST = rate_kbps(RATE_RST);

   // Block exchange address must fit four bits and be nonzero
   function automatic logic blk_addr_ok(input logic [6:0] node);
      blk_addr_ok = (node[6:4] == 3'h0) && (node[3:0] != 4'h0);
   endfunction

   function automatic logic [10:0] cob(input logic [10:0] base, input logic [6:0] node);
      cob = base + {4'h0, node};
   endfunction

   function automatic logic [7:0] nmt_code(input cbx_nmt_t st);
      case (st)
         ST_BOOT: nmt_code = 8'h00;
         ST_STOPPED: nmt_code = 8'h04;
         ST_OPER: nmt_code = 8'h05;
         default: nmt_code = 8'h7f;
      endcase
   endfunction
endpackage

// ==== sim/cbx_master_model.sv ====
`timescale 1ns/100ps
// Bus master stand-in: feeds frames, takes replies, may stall
module cbx_master_model (
   // Clock and stall control
   input wire logic core_clk,
   input wire logic stall,
   // Frames toward the node
   output logic rx_valid,
   output logic [10:0] rx_id,
   output logic [3:0] rx_dlc,
   output logic [63:0] rx_data,
   input wire logic rx_ready,
   // Frames from the node
   input wire logic tx_valid,
   input wire logic [10:0] tx_id,
   input wire logic [3:0] tx_dlc,
   input wire logic [63:0] tx_data,
   output logic tx_ready
);
   int cnt = 0;
   logic [10:0] got_id;
   logic [3:0] got_dlc;
   logic [63:0] got_data;
   // Idle at time zero
   initial begin
      rx_valid = 1'b0;
      rx_id = 11'h000;
      rx_dlc = 4'h0;
      rx_data = 64'h0;
      tx_ready = 1'b0;
   end
   // Capture each reply; ready follows stall one cycle late
   always @(posedge core_clk) begin
      if (tx_valid && tx_ready) begin
         cnt <= cnt + 1;
         got_id <= tx_id;
         got_dlc <= tx_dlc;
         got_data <= tx_data;
      end
      tx_ready <= !stall;
   end
   // Hold frame until taken, then scramble the released lines
   task automatic send(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] d);
      @(posedge core_clk);
      rx_valid <= 1'b1;
      rx_id <= id;
      rx_dlc <= dlc;
      rx_data <= d;
      do @(posedge core_clk); while (rx_ready !== 1'b1);
      rx_valid <= 1'b0;
      rx_id <= ~id;
      rx_dlc <= ~dlc;
      rx_data <= ~d;
   endtask
   // Broadcast sync, no data bytes
   task automatic sync_frame;
      send(cbx_pkg::SYNC_ID, cbx_pkg::SYNC_DLC, 64'h0);
   endtask
endmodule

// ==== sim/cbx_node_tb_top.sv ====
`timescale 1ns/100ps
module cbx_node_tb_top;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic stall = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic rx_valid, rx_ready, tx_valid, tx_ready;
   logic [10:0] rx_id, tx_id;
   logic [3:0] rx_dlc, tx_dlc;
   logic [63:0] rx_data, tx_data;
   logic [6:0] node_id;
   logic [9:0] bit_rate_kbps;
   logic [7:0] nmt_state;
   logic [63:0] sdo_req_data;
   logic sync_pulse, sdo_req_valid;
   logic emcy_req = 1'b0;
   logic sdo_resp_req = 1'b0;
   logic [9:0] prev = 10'h3e8;
   logic [9:0] kbps [8] = '{10'h07d, 10'h3e8, 10'h1f4, 10'h0fa, 10'h07d, 10'h032, 10'h014, 10'h00a};
   logic [63:0] blk = 64'hfedc_ba98_7654_3210;
   int bad_count = 0;
   int total_checks = 0;
   int cyc = 0;
   int n;
   int syncs = 0;
   int sdo_hits = 0;

   cbx_node dut (.core_clk, .rst_n, .ce(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .rx_valid, .rx_id, .rx_dlc, .rx_data, .rx_ready, .tx_valid, .tx_id, .tx_dlc,
      .tx_data, .tx_ready, .emcy_req, .emcy_data(~blk), .sdo_resp_req, .sdo_resp_data(blk),
      .sdo_req_valid, .sdo_req_data, .nmt_state, .node_id, .bit_rate_kbps, .sync_pulse);
   cbx_master_model m (.core_clk, .stall, .rx_valid, .rx_id, .rx_dlc, .rx_data, .rx_ready,
      .tx_valid, .tx_id, .tx_dlc, .tx_data, .tx_ready);

   always #5 core_clk = ~core_clk;
   // Hang guard, well above the expected run; strobe counts
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (sync_pulse) syncs <= syncs + 1;
      if (sdo_req_valid) sdo_hits <= sdo_hits + 1;
      if (cyc == 20000) begin
         bad_count++;
         end_of_test;
      end
   end

   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk("reg_rdata", {48'h0, exp}, {48'h0, reg_rdata});
   endtask
   task automatic wait_tx;
      n = m.cnt;
      for (int i = 0; i < 60 && m.cnt == n; i++) @(posedge core_clk);
      #1 chk("tx count", 64'(n + 1), 64'(m.cnt));
   endtask
   task automatic end_of_test;
      $display("Checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge core_clk);
      chk("boot id", 64'h701, {53'h0, m.got_id});
      chk("nmt_state", 64'h7f, {56'h0, nmt_state});
      rd_chk(4'h0, 16'h0001);
      rd_chk(4'h1, 16'h0001);
      rd_chk(4'h2, 16'h0000);
      rd_chk(4'hc, 16'h0000);
      chk("kbps", 64'h3e8, {54'h0, bit_rate_kbps});
      // Block waits in the buffer until sync
      for (int i = 0; i < 4; i++) wr(4'(8 + i), 16'(16'h1111 * (i + 1)));
      m.send({cbx_pkg::BLK_SEND_PFX, 4'h1}, cbx_pkg::BLK_DLC, blk);
      rd_chk(4'h3, 16'h0102);
      m.sync_frame;
      wait_tx;
      chk("reply id", {53'h0, cbx_pkg::BLK_REPLY_PFX, 4'h1}, {53'h0, m.got_id});
      chk("reply dlc", 64'h8, {60'h0, m.got_dlc});
      chk("reply data", 64'h4444_3333_2222_1111, m.got_data);
      for (int i = 0; i < 4; i++) rd_chk(4'(4 + i), blk[16 * i +: 16]);
      rd_chk(4'h3, 16'h0101);
      // Foreign block ignored; stalled reply lets the FIFO fill
      m.send({cbx_pkg::BLK_SEND_PFX, 4'h2}, cbx_pkg::BLK_DLC, ~blk);
      stall <= 1'b1;
      m.sync_frame;
      for (int i = 0; i < 16; i++) m.send(11'h7ff, 4'h0, 64'h0);
      repeat (2) @(posedge core_clk);
      chk("rx_ready full", 64'h0, {63'h0, rx_ready});
      stall <= 1'b0;
      wait_tx;
      chk("reply id", {53'h0, cbx_pkg::BLK_REPLY_PFX, 4'h1}, {53'h0, m.got_id});
      repeat (30) @(posedge core_clk);
      chk("rx_ready drained", 64'h1, {63'h0, rx_ready});
      rd_chk(4'h4, blk[15:0]);
      // Settings apply only on reinit
      for (int c = 0; c < 8; c++) begin
         wr(4'h0, 16'(c));
         #1 chk("kbps early", {54'h0, prev}, {54'h0, bit_rate_kbps});
         wr(4'h2, 16'h0001);
         repeat (3) @(posedge core_clk);
         #1 chk("kbps", {54'h0, kbps[c]}, {54'h0, bit_rate_kbps});
         prev = kbps[c];
      end
      wr(4'h1, 16'h0003);
      wr(4'h2, 16'h0001);
      repeat (10) @(posedge core_clk);
      chk("node_id", 64'h3, {57'h0, node_id});
      m.send(11'h703, 4'h0, 64'h0);
      wait_tx;
      chk("guard id", 64'h703, {53'h0, m.got_id});
      chk("guard data", 64'h7f, m.got_data);
      // Start command, one SDO request, then emergency ahead of SDO answer
      m.send(11'h000, 4'h2, 64'h0301);
      repeat (3) @(posedge core_clk);
      #1 chk("nmt_state", 64'h5, {56'h0, nmt_state});
      m.send(11'h603, 4'h8, blk);
      emcy_req <= 1'b1;
      sdo_resp_req <= 1'b1;
      @(posedge core_clk);
      emcy_req <= 1'b0;
      sdo_resp_req <= 1'b0;
      wait_tx;
      chk("emcy id", 64'h83, {53'h0, m.got_id});
      chk("emcy data", ~blk, m.got_data);
      wait_tx;
      chk("sdo id", 64'h583, {53'h0, m.got_id});
      chk("sdo data", blk, m.got_data);
      chk("sdo request", blk, sdo_req_data);
      chk("sdo strobes", 64'h1, 64'(sdo_hits));
      chk("sync pulses", 64'h2, 64'(syncs));
      end_of_test;
   end
endmodule
